/* File: pkg/tmsoc_pkg.sv */
// Constants and types shared by the timer status and output control block
package tmsoc_pkg;

   // ---------------------------------------------------------------
   // Register byte offsets on the APB bus
   // ---------------------------------------------------------------
   localparam logic [7:0] TMSOC_OFF_TSC0   = 8'h00; // Channel 0 status/control
   localparam logic [7:0] TMSOC_OFF_TSC1   = 8'h04; // Channel 1 status/control
   localparam logic [7:0] TMSOC_OFF_TSCX   = 8'h08; // Channel X status/control
   localparam logic [7:0] TMSOC_OFF_TSCY   = 8'h0C; // Channel Y status/control
   localparam logic [7:0] TMSOC_OFF_STC    = 8'h10; // Serial/timer control
   localparam logic [7:0] TMSOC_OFF_SYSC   = 8'h14; // System control

   // ---------------------------------------------------------------
   // Channel indices
   // ---------------------------------------------------------------
   localparam int TMSOC_CH0 = 0;                  // Channel 0
   localparam int TMSOC_CH1 = 1;                  // Channel 1
   localparam int TMSOC_CHX = 2;                  // Channel X
   localparam int TMSOC_CHY = 3;                  // Channel Y

   // ---------------------------------------------------------------
   // Field positions in a status/control register, and HIE in system control
   // ---------------------------------------------------------------
   localparam int TMSOC_B_MATCH_B = 7;            // Match B flag
   localparam int TMSOC_B_MATCH_A = 6;            // Match A flag
   localparam int TMSOC_B_WRAP    = 5;            // Wrap flag
   localparam int TMSOC_B_BIT4    = 4;            // Per-channel bit 4
   localparam int TMSOC_B_HIE     = 1;            // Host interface enable

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] TMSOC_RST_TSC    = 8'h00; // Channels 0, X, Y
   localparam logic [7:0] TMSOC_RST_TSC1   = 8'h10; // Channel 1
   localparam logic [7:0] TMSOC_RST_STC    = 8'h00; // Serial/timer control

   // ---------------------------------------------------------------
   // Output select codes
   // ---------------------------------------------------------------
   localparam logic [1:0] TMSOC_OS_NONE   = 2'h0;  // No change
   localparam logic [1:0] TMSOC_OS_LOW    = 2'h1;  // Drive 0
   localparam logic [1:0] TMSOC_OS_HIGH   = 2'h2;  // Drive 1
   localparam logic [1:0] TMSOC_OS_TOGGLE = 2'h3;  // Invert

   // Capture sequence states, Gray coded from IDLE through RISE to FALL
   typedef enum logic [1:0] {
      TMSOC_CAP_IDLE = 2'b00,                     // Not armed
      TMSOC_CAP_RISE = 2'b01,                     // Waiting for rising edge
      TMSOC_CAP_FALL = 2'b11                      // Waiting for falling edge
   } tmsoc_cap_t;

endpackage : tmsoc_pkg

/* File: design/tmsoc_top.sv */
// Status, flag and compare-match output control for a four channel timer
`timescale 1ns/10ps

module tmsoc_top
(
   input  wire logic        clock_i,        // System clock
   input  wire logic        rst_b_i,        // Synchronous reset, active low
   // APB slave
   input  wire logic        psel_i,         // Select
   input  wire logic        penable_i,      // Access phase
   input  wire logic        pwrite_i,       // Write when high
   input  wire logic [7:0]  paddr_i,        // Byte address
   input  wire logic [31:0] pwdata_i,       // Write data
   output logic             pready_o,       // Transfer done
   output logic [31:0]      prdata_o,       // Read data
   output logic             pslverr_o,      // Unmapped or blocked
   // Counter datapath events, one bit per channel
   input  wire logic [3:0]  match_a_i,      // Counter equals constant A
   input  wire logic [3:0]  match_b_i,      // Counter equals constant B
   input  wire logic [3:0]  wrap_i,         // Counter wrapped to zero
   input  wire logic [3:0]  xfer_ack_a_i,   // Transfer ctrl took match A
   input  wire logic [3:0]  xfer_ack_b_i,   // Transfer ctrl took match B
   // Clock select bits of each channel timer_control, 3 per channel
   input  wire logic [11:0] clk_sel_i,      // {Y, X, 1, 0}
   // Capture on channel X
   input  wire logic        capture_start_i, // Capture start bit
   input  wire logic        ext_reset_i,    // External reset signal
   output logic             capture_done_o, // Pulse, clears start bit
   // Results
   output logic [3:0]       match_a_irq_o,  // Match A request
   output logic [3:0]       match_b_irq_o,  // Match B request
   output logic [3:0]       wrap_irq_o,     // Wrap request
   output logic             capture_irq_o,  // Capture request
   output logic             converter_start_o, // Converter start pulse
   output logic [3:0]       timer_out_o,    // Timer output levels
   output logic [3:0]       timer_out_en_o, // Timer output enabled
   output logic [3:0]       tap0_o,         // Channel 0 log2 divisor
   output logic [3:0]       tap1_o          // Channel 1 log2 divisor
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [3:0][7:0]      tsc;            // Status/control per channel
      logic [3:0][3:0]      armed;          // Flags seen as 1 by a read
      logic [7:0]           stc;            // Serial/timer control
      logic                 host_if_enable;            // Host interface enable
      logic [3:0]           out_lvl;        // Timer output levels
      logic [3:0]           out_en;         // Timer output enables
      logic                 conv;           // Converter start pulse
      tmsoc_pkg::tmsoc_cap_t cap;           // Capture sequence
      logic                 ext_prev;       // Last external reset level
      logic                 cap_done;       // Capture done pulse
      logic                 cap_irq;        // Capture request
      logic [3:0]           tap0;           // Channel 0 divisor
      logic [3:0]           tap1;           // Channel 1 divisor
      logic                 pready;         // Bus ready
      logic [31:0]          prdata;         // Bus read data
      logic                 pslverr;        // Bus error
   } tmsoc_state_t;

   tmsoc_state_t st_r;                      // Registered state
   tmsoc_state_t st_nxt;                    // Next state

   // ---------------------------------------------------------------
   // Output action of one select code, with priority rank
   // ---------------------------------------------------------------
   function automatic logic [1:0] tmsoc_rank_f(input logic [1:0] sel,
                                               input logic       ev);
      logic [1:0] r;
      r = 2'h0;
      if (ev)
      begin
         r = sel;                           // Code order is the priority
      end
      return r;
   endfunction : tmsoc_rank_f

   // ---------------------------------------------------------------
   // Divisor for channel 0/1 internal clocks, 0 when not internal
   // ---------------------------------------------------------------
   function automatic logic [3:0] tmsoc_tap_f(input logic [2:0] cks,
                                              input logic       icks,
                                              input logic       ch1);
      logic [3:0] t;
      t = 4'h0;
      case (cks)
         3'h1:    t = icks ? 4'h1 : 4'h3;              // /2 or /8
         3'h2:    t = icks ? (ch1 ? 4'h7 : 4'h5) : 4'h6; // /128,/32,/64
         3'h3:    t = icks ? (ch1 ? 4'hB : 4'h8) : 4'hA; // /2048,/256,/1024
         default: t = 4'h0;                            // Not internal
      endcase
      return t;
   endfunction : tmsoc_tap_f

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   logic       setup;                       // Access phase first cycle
   logic       done;                        // Access completes this edge
   logic [2:0] reg_idx;                     // Register index
   logic       mapped;                      // Address is a register
   logic       blocked;                     // Host interface blocks it

   always_comb
   begin
      setup   = psel_i && penable_i && !st_r.pready;
      done    = psel_i && penable_i && st_r.pready;
      reg_idx = paddr_i[4:2];
      mapped  = (paddr_i[1:0] == 2'h0) && (paddr_i[7:5] == 3'h0) &&
                (reg_idx <= 3'h5);
      // Channel X/Y registers closed while host interface is on
      blocked = st_r.host_if_enable &&
                (reg_idx == 3'h2 || reg_idx == 3'h3);
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      logic [1:0] ra;                       // Rank of match A action
      logic [1:0] rb;                       // Rank of match B action
      logic [1:0] win;                      // Winning action
      logic       wr;                       // Write takes effect
      logic       rd;                       // Read takes effect
      logic [7:0] wd;                       // Written byte
      logic [3:0] setv;                     // Flags set this cycle
      logic       rise;                     // External rise
      logic       fall;                     // External fall
      ra      = 2'h0;
      rb      = 2'h0;
      win     = 2'h0;
      setv    = 4'h0;
      st_nxt  = st_r;
      wd      = pwdata_i[7:0];
      wr      = done && pwrite_i && mapped && !blocked;
      rd      = done && !pwrite_i && mapped && !blocked;
      rise    = ext_reset_i && !st_r.ext_prev;
      fall    = !ext_reset_i && st_r.ext_prev;
      st_nxt.ext_prev = ext_reset_i;
      st_nxt.cap_done = 1'b0;

      // Capture sequence on channel X
      case (st_r.cap)
         tmsoc_pkg::TMSOC_CAP_IDLE:
         begin
            if (capture_start_i)
            begin
               st_nxt.cap = tmsoc_pkg::TMSOC_CAP_RISE;
            end
         end
         tmsoc_pkg::TMSOC_CAP_RISE:
         begin
            if (!capture_start_i)
            begin
               st_nxt.cap = tmsoc_pkg::TMSOC_CAP_IDLE; // Start withdrawn
            end
            else if (rise)
            begin
               st_nxt.cap = tmsoc_pkg::TMSOC_CAP_FALL;
            end
         end
         tmsoc_pkg::TMSOC_CAP_FALL:
         begin
            if (fall)
            begin
               st_nxt.cap      = tmsoc_pkg::TMSOC_CAP_IDLE;
               st_nxt.cap_done = 1'b1;
            end
         end
         default:
         begin
            st_nxt.cap = tmsoc_pkg::TMSOC_CAP_IDLE;
         end
      endcase

      // Flags and output actions per channel
      for (int c = 0; c < 4; c++)
      begin
         setv[3] = match_b_i[c];
         setv[2] = match_a_i[c];
         setv[1] = wrap_i[c];
         setv[0] = (c == tmsoc_pkg::TMSOC_CHX) && st_nxt.cap_done;

         // Read arms only flags that were seen as 1
         if (rd && reg_idx == 3'(c))
         begin
            st_nxt.armed[c] = st_r.prdata[7:4];
            if (c != tmsoc_pkg::TMSOC_CHX)
            begin
               st_nxt.armed[c][0] = 1'b0;
            end
         end

         // Zero write clears an armed flag; one has no effect
         if (wr && reg_idx == 3'(c))
         begin
            for (int f = 0; f < 4; f++)
            begin
               if (!wd[4 + f] && st_r.armed[c][f])
               begin
                  st_nxt.tsc[c][4 + f] = 1'b0;
               end
            end
            st_nxt.armed[c] = 4'h0;
            st_nxt.tsc[c][3:0] = wd[3:0];
            if (c == tmsoc_pkg::TMSOC_CH0 || c == tmsoc_pkg::TMSOC_CHY)
            begin
               st_nxt.tsc[c][tmsoc_pkg::TMSOC_B_BIT4] = wd[4];
            end
         end

         // Transfer controller activation clears match flags
         if (xfer_ack_b_i[c])
         begin
            st_nxt.tsc[c][tmsoc_pkg::TMSOC_B_MATCH_B] = 1'b0;
            st_nxt.armed[c][3] = 1'b0;      // A later set must survive
         end
         if (xfer_ack_a_i[c])
         begin
            st_nxt.tsc[c][tmsoc_pkg::TMSOC_B_MATCH_A] = 1'b0;
            st_nxt.armed[c][2] = 1'b0;      // A later set must survive
         end

         // Hardware set wins over any clear in the same cycle
         for (int f = 0; f < 4; f++)
         begin
            if (setv[f])
            begin
               st_nxt.tsc[c][4 + f] = 1'b1;
            end
         end

         // Channel 1 bit 4 is a constant one
         if (c == tmsoc_pkg::TMSOC_CH1)
         begin
            st_nxt.tsc[c][tmsoc_pkg::TMSOC_B_BIT4] = 1'b1;
         end

         // Highest ranked action of the two matches wins
         rb  = tmsoc_rank_f(st_r.tsc[c][3:2], match_b_i[c]);
         ra  = tmsoc_rank_f(st_r.tsc[c][1:0], match_a_i[c]);
         win = (rb > ra) ? rb : ra;
         case (win)
            tmsoc_pkg::TMSOC_OS_LOW:    st_nxt.out_lvl[c] = 1'b0;
            tmsoc_pkg::TMSOC_OS_HIGH:   st_nxt.out_lvl[c] = 1'b1;
            tmsoc_pkg::TMSOC_OS_TOGGLE: st_nxt.out_lvl[c] = !st_r.out_lvl[c];
            default:                    st_nxt.out_lvl[c] = st_r.out_lvl[c];
         endcase

         // Output enable registered from the new select bits
         st_nxt.out_en[c] = |st_nxt.tsc[c][3:0];
      end

      // Converter start from channel 0 match A
      st_nxt.conv = match_a_i[tmsoc_pkg::TMSOC_CH0] &&
                    st_r.tsc[tmsoc_pkg::TMSOC_CH0][tmsoc_pkg::TMSOC_B_BIT4];

      // Capture request gated by channel Y enable
      st_nxt.cap_irq =
         st_nxt.tsc[tmsoc_pkg::TMSOC_CHX][tmsoc_pkg::TMSOC_B_BIT4] &&
         st_nxt.tsc[tmsoc_pkg::TMSOC_CHY][tmsoc_pkg::TMSOC_B_BIT4];

      // Serial/timer control and system control writes
      if (wr && reg_idx == 3'h4)
      begin
         st_nxt.stc = wd;                   // Software keeps bit 2 clear
      end
      if (wr && reg_idx == 3'h5)
      begin
         st_nxt.host_if_enable = wd[tmsoc_pkg::TMSOC_B_HIE];
      end

      // Clock divisor taps from both select fields
      st_nxt.tap0 = tmsoc_rank_tap(0);
      st_nxt.tap1 = tmsoc_rank_tap(1);

      // APB answer: one wait state, data sampled in the first cycle
      st_nxt.pready  = setup;
      st_nxt.pslverr = setup && (!mapped || blocked);
      st_nxt.prdata  = 32'h0;
      if (setup && !pwrite_i && mapped && !blocked)
      begin
         case (reg_idx)
            3'h0, 3'h1, 3'h2, 3'h3:
               st_nxt.prdata[7:0] = st_r.tsc[reg_idx[1:0]];
            3'h4:    st_nxt.prdata[7:0] = st_r.stc;
            3'h5:    st_nxt.prdata[tmsoc_pkg::TMSOC_B_HIE] = st_r.host_if_enable;
            default: st_nxt.prdata = 32'h0;
         endcase
      end
      if (!psel_i)
      begin
         st_nxt.pready = 1'b0;              // Abandoned transfer
      end

      // Synchronous reset values
      if (!rst_b_i)
      begin
         st_nxt          = '0;
         st_nxt.tsc[0]   = tmsoc_pkg::TMSOC_RST_TSC;
         st_nxt.tsc[1]   = tmsoc_pkg::TMSOC_RST_TSC1;
         st_nxt.tsc[2]   = tmsoc_pkg::TMSOC_RST_TSC;
         st_nxt.tsc[3]   = tmsoc_pkg::TMSOC_RST_TSC;
         st_nxt.stc      = tmsoc_pkg::TMSOC_RST_STC;
         st_nxt.out_lvl  = 4'h0;
         st_nxt.cap      = tmsoc_pkg::TMSOC_CAP_IDLE;
      end
   end

   // ---------------------------------------------------------------
   // Tap helper: channel 0 uses select bit 0, channel 1 bit 1
   // ---------------------------------------------------------------
   function automatic logic [3:0] tmsoc_rank_tap(input int ch);
      logic [3:0] t;
      t = 4'h0;
      if (ch == 0)
      begin
         t = tmsoc_tap_f(clk_sel_i[2:0], st_r.stc[0], 1'b0);
      end
      else
      begin
         t = tmsoc_tap_f(clk_sel_i[5:3], st_r.stc[1], 1'b1);
      end
      return t;
   endfunction : tmsoc_rank_tap

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i)
   begin
      st_r <= st_nxt;
   end

   // ---------------------------------------------------------------
   // Outputs, all from flip-flops
   // ---------------------------------------------------------------
   always_comb
   begin
      pready_o          = st_r.pready;
      prdata_o          = st_r.prdata;
      pslverr_o         = st_r.pslverr;
      capture_done_o    = st_r.cap_done;
      capture_irq_o     = st_r.cap_irq;
      converter_start_o = st_r.conv;
      timer_out_o       = st_r.out_lvl;
      tap0_o            = st_r.tap0;
      tap1_o            = st_r.tap1;
      for (int c = 0; c < 4; c++)
      begin
         match_b_irq_o[c]  = st_r.tsc[c][tmsoc_pkg::TMSOC_B_MATCH_B];
         match_a_irq_o[c]  = st_r.tsc[c][tmsoc_pkg::TMSOC_B_MATCH_A];
         wrap_irq_o[c]     = st_r.tsc[c][tmsoc_pkg::TMSOC_B_WRAP];
         timer_out_en_o[c] = st_r.out_en[c];
      end
   end

endmodule : tmsoc_top

/* File: tb/tmsoc_monitor.sv */
// Port assertions for the timer status and output control block
`timescale 1ns/10ps
module tmsoc_monitor
(
   input wire logic       clock_i,
   input wire logic       rst_b_i,
   input wire logic       psel_i,
   input wire logic       penable_i,
   input wire logic       pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic       pready_o,
   input wire logic       pslverr_o,
   input wire logic [3:0] match_a_i,
   input wire logic [3:0] match_b_i,
   input wire logic [3:0] wrap_i,
   input wire logic [3:0] xfer_ack_a_i,
   input wire logic [3:0] xfer_ack_b_i,
   input wire logic [3:0] match_a_irq_o,
   input wire logic [3:0] match_b_irq_o,
   input wire logic [3:0] wrap_irq_o,
   input wire logic       capture_irq_o,
   input wire logic       capture_done_o,
   input wire logic       converter_start_o,
   input wire logic [3:0] timer_out_o
);
   // ---------------------------------------------------------------
   // Helper logic and defaults
   // ---------------------------------------------------------------
   logic wr_done;   // Write completing at this edge
   assign wr_done = psel_i && penable_i && pwrite_i && pready_o;
   default clocking mon_cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_b_i);
   // ---------------------------------------------------------------
   // Flags, outputs and bus answers
   // ---------------------------------------------------------------
   AST_MB_SET: assert property (match_b_i[0] |=> match_b_irq_o[0])
      else $error("match B flag not raised");
   AST_XFER_B: assert property
      (xfer_ack_b_i[0] && !match_b_i[0] |=> !match_b_irq_o[0])
      else $error("match B flag kept after transfer");
   AST_MA_SET: assert property (match_a_i[0] |=> match_a_irq_o[0])
      else $error("match A flag not raised");
   AST_XFER_A: assert property
      (xfer_ack_a_i[0] && !match_a_i[0] |=> !match_a_irq_o[0])
      else $error("match A flag kept after transfer");
   AST_WRAP_SET: assert property (wrap_i[0] |=> wrap_irq_o[0])
      else $error("wrap flag not raised");
   AST_WRAP_HOLD: assert property ($fell(wrap_irq_o[0]) |->
      $past(wr_done && paddr_i == 8'h00))
      else $error("wrap flag fell without a write");
   AST_CONV: assert property (converter_start_o |-> $past(match_a_i[0]))
      else $error("converter start without match A");
   AST_CAP_IRQ: assert property ($rose(capture_irq_o) |->
      capture_done_o || $past(capture_done_o) || $past(wr_done))
      else $error("capture request without cause");
   AST_OUT_HOLD: assert property (((timer_out_o ^ $past(timer_out_o))
      & ~$past(match_a_i | match_b_i)) == 4'h0)
      else $error("timer output moved without a match");
   AST_OPEN_OK: assert property (pready_o &&
      paddr_i inside {8'h00, 8'h04, 8'h10, 8'h14} |-> !pslverr_o)
      else $error("error on an always open register");
   COV_CAP: cover property (capture_done_o);
   COV_CONV: cover property (converter_start_o);
   COV_ERR: cover property (pready_o && pslverr_o);
endmodule : tmsoc_monitor

bind tmsoc_top tmsoc_monitor tmsoc_monitor_i (.clock_i, .rst_b_i, .psel_i,
   .penable_i, .pwrite_i, .paddr_i, .pready_o, .pslverr_o, .match_a_i,
   .match_b_i, .wrap_i, .xfer_ack_a_i, .xfer_ack_b_i, .match_a_irq_o,
   .match_b_irq_o, .wrap_irq_o, .capture_irq_o, .capture_done_o,
   .converter_start_o, .timer_out_o);

/* File: tb/tb_tmsoc_top.sv */
// Self-checking bench for the timer status and output control block
`timescale 1ns/10ps
module tb_tmsoc_top;
   // ---------------------------------------------------------------
   // Design signals and counters
   // ---------------------------------------------------------------
   logic clock_i = 1'h0, rst_b_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0;
   logic pwrite_i = 1'h0, capture_start_i = 1'h0, ext_reset_i = 1'h0;
   logic [7:0]  paddr_i = 8'h00;      // Bus address
   logic [31:0] pwdata_i = 32'h0;     // Bus write data
   logic [11:0] clk_sel_i = 12'h011;  // Ch1 code 010, ch0 code 001
   logic [3:0]  match_a_i = 4'h0, match_b_i = 4'h0, wrap_i = 4'h0;
   logic [3:0]  xfer_ack_a_i = 4'h0, xfer_ack_b_i = 4'h0;
   logic pready_o, pslverr_o, capture_done_o, capture_irq_o;
   logic converter_start_o;
   logic [31:0] prdata_o;
   logic [3:0]  match_a_irq_o, match_b_irq_o, wrap_irq_o, timer_out_o;
   logic [3:0]  timer_out_en_o, tap0_o, tap1_o;
   int          failures = 0;         // Mismatches seen
   int          n_checks = 0;         // Comparisons made
   tmsoc_top tmsoc_top_i (.*);
   always #20 clock_i = ~clock_i;
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic report_and_stop();
      if (failures == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [7:0] g, e);
      n_checks++;
      if (g !== e)
      begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // Waits out a bounded number of edges for a high flag
   task automatic await(ref logic f);
      int k = 0;
      do
      begin
         @(posedge clock_i);
         #1;
         k++;
      end
      while (f !== 1'h1 && k < 20);
      if (f !== 1'h1)
      begin
         failures++;
         report_and_stop();
      end
   endtask : await
   // One APB transfer, request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, d,
                      output logic [7:0] r, output logic e);
      @(posedge clock_i);
      psel_i   <= 1'h1;
      pwrite_i <= w;
      paddr_i  <= a;
      pwdata_i <= {24'h0, d};
      @(posedge clock_i);
      penable_i <= 1'h1;
      await(pready_o);
      r = prdata_o[7:0];
      e = pslverr_o;
      @(posedge clock_i);
      psel_i    <= 1'h0;
      penable_i <= 1'h0;
   endtask : apb
   task automatic wr(input logic [7:0] a, d);
      logic [7:0] r;
      logic       e;
      apb(1'h1, a, d, r, e);
   endtask : wr
   task automatic rdchk(input logic [7:0] a, x, input logic xe);
      logic [7:0] r;
      logic       e;
      apb(1'h0, a, 8'h00, r, e);
      chk(r, x);
      chk({7'h0, e}, {7'h0, xe});
   endtask : rdchk
   // One-cycle event pulses: match A, match B, wrap, acks A and B
   task automatic ev(input logic [3:0] ma, mb, wp, aa, ab);
      @(posedge clock_i);
      match_a_i    <= ma;
      match_b_i    <= mb;
      wrap_i       <= wp;
      xfer_ack_a_i <= aa;
      xfer_ack_b_i <= ab;
      @(posedge clock_i);
      {match_a_i, match_b_i, wrap_i} <= 12'h000;
      {xfer_ack_a_i, xfer_ack_b_i}   <= 8'h00;
      #1;
   endtask : ev
   task automatic settle();
      repeat (2) @(posedge clock_i);
      #1;
   endtask : settle
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] ad [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
      logic [7:0] rv [6] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
      chk({4'h0, timer_out_o}, 8'h00);
      foreach (ad[i]) rdchk(ad[i], rv[i], 1'h0);
   endtask : t_reset
   // Ones written to flags and a zero to the fixed bit change nothing
   task automatic t_fixed();
      wr(8'h04, 8'hEF);
      rdchk(8'h04, 8'h1F, 1'h0);
      wr(8'h04, 8'h00);
      settle();
      chk({7'h0, timer_out_en_o[1]}, 8'h00);
   endtask : t_fixed
   // Clearing needs a read first; a flag set after the read survives
   task automatic t_flags();
      ev(4'h0, 4'h1, 4'h0, 4'h0, 4'h0);
      wr(8'h00, 8'h00);
      rdchk(8'h00, 8'h80, 1'h0);
      wr(8'h00, 8'h00);
      rdchk(8'h00, 8'h00, 1'h0);
      ev(4'h0, 4'h0, 4'h1, 4'h0, 4'h0);
      chk({4'h0, wrap_irq_o}, 8'h01);
      rdchk(8'h00, 8'h20, 1'h0);
      ev(4'h1, 4'h0, 4'h0, 4'h0, 4'h0);
      wr(8'h00, 8'h00);
      rdchk(8'h00, 8'h40, 1'h0);
      chk({4'h0, wrap_irq_o}, 8'h00);
      ev(4'h0, 4'h1, 4'h0, 4'h0, 4'h0);
      ev(4'h0, 4'h0, 4'h0, 4'h1, 4'h1);
      chk({6'h0, match_a_irq_o[0], match_b_irq_o[0]}, 8'h00);
   endtask : t_flags
   task automatic t_conv();
      wr(8'h00, 8'h10);
      ev(4'h1, 4'h0, 4'h0, 4'h0, 4'h0);
      chk({7'h0, converter_start_o}, 8'h01);
      wr(8'h00, 8'h00);
      ev(4'h1, 4'h0, 4'h0, 4'h0, 4'h0);
      chk({7'h0, converter_start_o}, 8'h00);
      ev(4'h0, 4'h0, 4'h0, 4'h1, 4'h0);
   endtask : t_conv
   // Every select code for A then B, then simultaneous matches
   task automatic t_out();
      logic [1:0] cd [5] = '{2'h2, 2'h0, 2'h1, 2'h3, 2'h3};
      logic       ex [5] = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0};
      logic [7:0] pr [3] = '{8'h09, 8'h07, 8'h06};
      logic       pe [3] = '{1'h1, 1'h0, 1'h1};
      for (int i = 0; i < 10; i++)
      begin
         wr(8'h04, (i < 5) ? {6'h0, cd[i % 5]} : {4'h0, cd[i % 5], 2'h0});
         ev((i < 5) ? 4'h2 : 4'h0, (i < 5) ? 4'h0 : 4'h2, 4'h0, 4'h0, 4'h0);
         chk({7'h0, timer_out_o[1]}, {7'h0, ex[i % 5]});
      end
      foreach (pr[i])
      begin
         wr(8'h04, pr[i]);
         ev(4'h2, 4'h2, 4'h0, 4'h0, 4'h0);
         chk({7'h0, timer_out_o[1]}, {7'h0, pe[i]});
      end
      chk({7'h0, timer_out_en_o[1]}, 8'h01);
   endtask : t_out
   task automatic t_host();
      wr(8'h14, 8'h02);
      rdchk(8'h08, 8'h00, 1'h1);
      rdchk(8'h00, 8'h00, 1'h0);
      wr(8'h14, 8'h00);
      rdchk(8'h0C, 8'h00, 1'h0);
      rdchk(8'h18, 8'h00, 1'h1);
   endtask : t_host
   task automatic t_cap();
      wr(8'h0C, 8'h10);
      @(posedge clock_i);
      capture_start_i <= 1'h1;
      repeat (2) @(posedge clock_i);
      ext_reset_i <= 1'h1;
      repeat (2) @(posedge clock_i);
      ext_reset_i <= 1'h0;
      await(capture_done_o);
      @(posedge clock_i);
      capture_start_i <= 1'h0;
      settle();
      chk({7'h0, capture_irq_o}, 8'h01);
      rdchk(8'h08, 8'h10, 1'h0);
      wr(8'h08, 8'h00);
      rdchk(8'h08, 8'h00, 1'h0);
      chk({7'h0, capture_irq_o}, 8'h00);
   endtask : t_cap
   task automatic t_clk();
      wr(8'h10, 8'h03);
      settle();
      chk({tap1_o, tap0_o}, 8'h71);
      wr(8'h10, 8'h00);
      settle();
      chk({tap1_o, tap0_o}, 8'h63);
   endtask : t_clk
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge clock_i);
      rst_b_i <= 1'h1;
      t_reset();
      t_fixed();
      t_flags();
      t_conv();
      t_out();
      t_host();
      t_cap();
      t_clk();
      report_and_stop();
   end
endmodule : tb_tmsoc_top
